// ==== src/dac_ctrl_pkg.sv ====
// constants, register map and mode codes of the converter control block
package dac_ctrl_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL   = 8'h00;
    localparam logic [7:0] IDX_SPARE_ONE = 8'h01;
    localparam logic [7:0] IDX_LEVEL     = 8'h02;
    localparam logic [7:0] IDX_SPARE_LO  = 8'h03;
    localparam logic [7:0] IDX_SPARE_HI  = 8'h06;
    localparam logic [7:0] IDX_TEST      = 8'h07;
    localparam int         ADDR_LSB      = 2;
    localparam int         INDEX_W       = 8;

    // control register field positions
    localparam int RANGE_BIT = 7;
    localparam int DRIVE_BIT = 6;
    localparam int MODE_MSB  = 2;
    localparam int MODE_LSB  = 0;
    localparam int MODE_W    = 3;

    // mode codes
    localparam logic [2:0] MODE_OFF       = 3'h0;
    localparam logic [2:0] MODE_AMP_ONLY  = 3'h1;
    localparam logic [2:0] MODE_INTERNAL  = 3'h2;
    localparam logic [2:0] MODE_UNBUF     = 3'h4;
    localparam logic [2:0] MODE_UNBUF_AMP = 3'h5;
    localparam logic [2:0] MODE_BUFFERED  = 3'h7;

    // reset values and masks
    localparam logic       RANGE_RESET     = 1'b1;
    localparam logic       DRIVE_RESET     = 1'b0;
    localparam logic [7:0] LEVEL_RESET     = 8'h00;
    localparam logic [7:0] TEST_RESET      = 8'h00;
    localparam logic [7:0] TEST_WRITE_MASK = 8'h7f;
    localparam logic [7:0] ZERO_BYTE       = 8'h00;

    // ahb-lite codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    // true for every mode code that a write may install
    function automatic logic mode_is_supported(input logic [2:0] code);
        mode_is_supported = (code == MODE_OFF) || (code == MODE_AMP_ONLY)
                         || (code == MODE_INTERNAL) || (code == MODE_UNBUF)
                         || (code == MODE_UNBUF_AMP)
                         || (code == MODE_BUFFERED);
    endfunction : mode_is_supported

    // true for the modes that route the network to the unbuffered pin
    function automatic logic mode_is_unbuffered(input logic [2:0] code);
        mode_is_unbuffered = (code == MODE_UNBUF) || (code == MODE_UNBUF_AMP);
    endfunction : mode_is_unbuffered

endpackage : dac_ctrl_pkg

// ==== src/reg_access_if.sv ====
// register access carrier between the bus port and the register file
`timescale 1ns/100ps
interface reg_access_if;
    logic       wr_stb;  // one-cycle write strobe, data phase
    logic [7:0] index;   // register index of the current data phase
    logic [7:0] wdata;   // write byte
    logic [7:0] rdata;   // read byte for index

    modport port (output wr_stb, output index, output wdata, input rdata);
    modport regs (input wr_stb, input index, input wdata, output rdata);
endinterface : reg_access_if

// ==== src/ahb_register_port.sv ====
// ahb-lite slave front end that turns transfers into register accesses
`timescale 1ns/100ps
module ahb_register_port
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    reg_access_if.port       bus
);
    logic       phase_wr_ff;
    logic       nxt_phase_wr;
    logic [7:0] phase_idx_ff;
    logic [7:0] nxt_phase_idx;
    logic       take;

    // address phase accepted when selected, active and bus ready
    assign take = hsel && hready && htrans[1];

    // capture address phase for the following data phase
    always_comb
    begin
        nxt_phase_wr  = take && hwrite;
        nxt_phase_idx = phase_idx_ff;
        if (take)
        begin
            nxt_phase_idx = haddr[dac_ctrl_pkg::ADDR_LSB +: 8];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase_wr_ff  <= 1'b0;
            phase_idx_ff <= 8'h00;
        end
        else
        begin
            phase_wr_ff  <= nxt_phase_wr;
            phase_idx_ff <= nxt_phase_idx;
        end
    end

    // zero wait states, always okay, low byte carries the register
    assign hreadyout  = 1'b1;
    assign hresp      = dac_ctrl_pkg::HRESP_OKAY;
    assign bus.wr_stb = phase_wr_ff;
    assign bus.index  = phase_idx_ff;
    assign bus.wdata  = hwdata[7:0];
    assign hrdata     = {24'h000000, bus.rdata};
endmodule : ahb_register_port

// ==== src/mode_route_decoder.sv ====
// decodes the mode and stop state into enables and switch controls
`timescale 1ns/100ps
module mode_route_decoder
(
    input  wire logic [2:0] mode,
    input  wire logic       cpu_stop,
    output logic            network_en,
    output logic            amp_en,
    output logic            feedback_switch,
    output logic            buffer_switch,
    output logic            direct_output_switch
);
    // per-mode routing table, stop overrides amplifier and two switches
    always_comb
    begin
        network_en           = 1'b0;
        amp_en               = 1'b0;
        feedback_switch      = 1'b0;
        buffer_switch        = 1'b0;
        direct_output_switch = 1'b0;
        case (mode)
            dac_ctrl_pkg::MODE_AMP_ONLY:
            begin
                amp_en          = 1'b1;
                feedback_switch = 1'b1;
            end
            dac_ctrl_pkg::MODE_INTERNAL:
            begin
                network_en = 1'b1;
            end
            dac_ctrl_pkg::MODE_UNBUF:
            begin
                network_en           = 1'b1;
                direct_output_switch = 1'b1;
            end
            dac_ctrl_pkg::MODE_UNBUF_AMP:
            begin
                network_en           = 1'b1;
                amp_en               = 1'b1;
                feedback_switch      = 1'b1;
                direct_output_switch = 1'b1;
            end
            dac_ctrl_pkg::MODE_BUFFERED:
            begin
                network_en    = 1'b1;
                amp_en        = 1'b1;
                buffer_switch = 1'b1;
            end
            default:
            begin
                network_en = 1'b0;
            end
        endcase
        if (cpu_stop)
        begin
            amp_en          = 1'b0;
            feedback_switch = 1'b0;
            buffer_switch   = 1'b0;
        end
    end
endmodule : mode_route_decoder

// ==== src/dac_mode_and_level_control.sv ====
// top of the converter control block: registers, stop handling, outputs
//
// Summary of operation
// - a byte control register at index 0 holds range in bit 7, drive in bit 6, mode in bits 2:0, with bits 5:3 reading zero.
// - range bit cleared runs the network over the reduced range, set runs it over the full range.
// - drive bit 0 asks for low amplifier drive, 1 for high amplifier drive.
// - mode codes 000, 001, 010, 100, 101 and 111 are off, amplifier, internal, unbuffered, unbuffered plus amplifier and buffered; others are reserved.
// - a control write with a reserved mode code leaves the old mode in force.
// - a read/write 8-bit level register at index 2 sets, with the range bit, the converter code.
// - the test register at index 7 is always readable and takes writes only in special mode.
// - in cpu stop the amplifier is off and the feedback and buffer switches are open regardless of mode.
// - all configuration contents survive stop entry and exit unchanged.
// - if an unbuffered mode was active before stop, the unbuffered pin is pulled to the high reference in stop.
// - feedback switch closes in 001 and 101, buffer switch only in 111, direct switch in 100 and 101; network on in 010, 100, 101, 111; amplifier on in 001, 101, 111.
// - after reset the mode is off, network and amplifier are disabled and all switches are open.
`timescale 1ns/100ps
module dac_mode_and_level_control
#(
    parameter int LEVEL_W = 8
)
(
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire logic               cpu_stop,
    input  wire logic               special_mode,
    output logic                    wide_range_select,
    output logic                    amp_high_drive,
    output logic      [LEVEL_W-1:0] output_level_code,
    output logic                    network_enable,
    output logic                    amp_enable,
    output logic                    feedback_switch,
    output logic                    buffer_switch,
    output logic                    direct_output_switch,
    output logic                    unbuffered_out_pin_high,
    output logic      [7:0]         factory_test_bits
);
    // register access carrier
    reg_access_if bus ();

    // configuration registers
    logic               range_ff;
    logic               nxt_range;
    logic               drive_ff;
    logic               nxt_drive;
    logic [2:0]         mode_ff;
    logic [2:0]         nxt_mode;
    logic [LEVEL_W-1:0] level_ff;
    logic [LEVEL_W-1:0] nxt_level;
    logic [7:0]         test_ff;
    logic [7:0]         nxt_test;

    // stop tracking
    logic               stop_ff;
    logic               nxt_stop;
    logic               unbuf_at_stop_ff;
    logic               nxt_unbuf_at_stop;

    // registered analog controls
    logic               net_en_ff;
    logic               nxt_net_en;
    logic               amp_en_ff;
    logic               nxt_amp_en;
    logic               fb_sw_ff;
    logic               nxt_fb_sw;
    logic               buf_sw_ff;
    logic               nxt_buf_sw;
    logic               dir_sw_ff;
    logic               nxt_dir_sw;
    logic               pull_high_ff;
    logic               nxt_pull_high;

    // decoder results
    logic               dec_net_en;
    logic               dec_amp_en;
    logic               dec_fb_sw;
    logic               dec_buf_sw;
    logic               dec_dir_sw;

    // write strobes per register
    logic               wr_control;
    logic               wr_level;
    logic               wr_test;
    logic [2:0]         wr_mode_code;
    // qualified strobes
    logic               wr_mode_ok;
    logic               wr_test_open;

    // bus front end
    ahb_register_port u_port
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .bus       (bus.port)
    );

    // routing decode from the stored mode and the stop level
    mode_route_decoder u_decoder
    (
        .mode                 (mode_ff),
        .cpu_stop             (cpu_stop),
        .network_en           (dec_net_en),
        .amp_en               (dec_amp_en),
        .feedback_switch      (dec_fb_sw),
        .buffer_switch        (dec_buf_sw),
        .direct_output_switch (dec_dir_sw)
    );

    // address decode of the data phase write
    assign wr_control   = bus.wr_stb
                       && (bus.index == dac_ctrl_pkg::IDX_CONTROL);
    assign wr_level     = bus.wr_stb && (bus.index == dac_ctrl_pkg::IDX_LEVEL);
    assign wr_test      = bus.wr_stb && (bus.index == dac_ctrl_pkg::IDX_TEST);
    assign wr_mode_code = bus.wdata[dac_ctrl_pkg::MODE_MSB:
                                    dac_ctrl_pkg::MODE_LSB];
    assign wr_mode_ok   = dac_ctrl_pkg::mode_is_supported(wr_mode_code);
    assign wr_test_open = wr_test && special_mode;

    // next values of the configuration registers; stop never touches them
    always_comb
    begin
        nxt_range = range_ff;
        nxt_drive = drive_ff;
        nxt_mode  = mode_ff;
        nxt_level = level_ff;
        nxt_test  = test_ff;
        if (wr_control)
        begin
            nxt_range = bus.wdata[dac_ctrl_pkg::RANGE_BIT];
            nxt_drive = bus.wdata[dac_ctrl_pkg::DRIVE_BIT];
            if (wr_mode_ok)
            begin
                nxt_mode = wr_mode_code;
            end
        end
        if (wr_level)
        begin
            nxt_level = bus.wdata[LEVEL_W-1:0];
        end
        if (wr_test_open)
        begin
            nxt_test = bus.wdata & dac_ctrl_pkg::TEST_WRITE_MASK;
        end
    end

    // configuration registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            range_ff <= dac_ctrl_pkg::RANGE_RESET;
            drive_ff <= dac_ctrl_pkg::DRIVE_RESET;
            mode_ff  <= dac_ctrl_pkg::MODE_OFF;
            level_ff <= LEVEL_W'(dac_ctrl_pkg::LEVEL_RESET);
            test_ff  <= dac_ctrl_pkg::TEST_RESET;
        end
        else
        begin
            range_ff <= nxt_range;
            drive_ff <= nxt_drive;
            mode_ff  <= nxt_mode;
            level_ff <= nxt_level;
            test_ff  <= nxt_test;
        end
    end

    // read mux; unmapped and spare indices answer zero
    always_comb
    begin
        bus.rdata = dac_ctrl_pkg::ZERO_BYTE;
        case (bus.index) inside
            dac_ctrl_pkg::IDX_CONTROL:
            begin
                bus.rdata = {range_ff, drive_ff, 3'h0, mode_ff};
            end
            dac_ctrl_pkg::IDX_LEVEL:
            begin
                bus.rdata = 8'(level_ff);
            end
            dac_ctrl_pkg::IDX_TEST:
            begin
                bus.rdata = test_ff;
            end
            dac_ctrl_pkg::IDX_SPARE_ONE,
            [dac_ctrl_pkg::IDX_SPARE_LO:dac_ctrl_pkg::IDX_SPARE_HI]:
            begin
                bus.rdata = dac_ctrl_pkg::ZERO_BYTE;
            end
            default:
            begin
                bus.rdata = dac_ctrl_pkg::ZERO_BYTE;
            end
        endcase
    end

    // stop entry remembers whether the unbuffered path was in use
    always_comb
    begin
        nxt_stop          = cpu_stop;
        nxt_unbuf_at_stop = unbuf_at_stop_ff;
        if (cpu_stop && !stop_ff)
        begin
            nxt_unbuf_at_stop = dac_ctrl_pkg::mode_is_unbuffered(mode_ff);
        end
        else if (!cpu_stop)
        begin
            nxt_unbuf_at_stop = 1'b0;
        end
    end

    // stop state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stop_ff          <= 1'b0;
            unbuf_at_stop_ff <= 1'b0;
        end
        else
        begin
            stop_ff          <= nxt_stop;
            unbuf_at_stop_ff <= nxt_unbuf_at_stop;
        end
    end

    // analog control outputs, registered one cycle after their cause
    always_comb
    begin
        nxt_net_en    = dec_net_en;
        nxt_amp_en    = dec_amp_en;
        nxt_fb_sw     = dec_fb_sw;
        nxt_buf_sw    = dec_buf_sw;
        nxt_dir_sw    = dec_dir_sw;
        nxt_pull_high = 1'b0;
        // held through stop once latched on entry
        if (cpu_stop && stop_ff && unbuf_at_stop_ff)
        begin
            nxt_pull_high = 1'b1;
        end
        else if (cpu_stop && !stop_ff)
        begin
            nxt_pull_high =
                dac_ctrl_pkg::mode_is_unbuffered(mode_ff);
        end
    end

    // analog control registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            net_en_ff    <= 1'b0;
            amp_en_ff    <= 1'b0;
            fb_sw_ff     <= 1'b0;
            buf_sw_ff    <= 1'b0;
            dir_sw_ff    <= 1'b0;
            pull_high_ff <= 1'b0;
        end
        else
        begin
            net_en_ff    <= nxt_net_en;
            amp_en_ff    <= nxt_amp_en;
            fb_sw_ff     <= nxt_fb_sw;
            buf_sw_ff    <= nxt_buf_sw;
            dir_sw_ff    <= nxt_dir_sw;
            pull_high_ff <= nxt_pull_high;
        end
    end

    // outputs toward the analog section
    assign wide_range_select       = range_ff;
    assign amp_high_drive          = drive_ff;
    assign output_level_code       = level_ff;
    assign network_enable          = net_en_ff;
    assign amp_enable              = amp_en_ff;
    assign feedback_switch         = fb_sw_ff;
    assign buffer_switch           = buf_sw_ff;
    assign direct_output_switch    = dir_sw_ff;
    assign unbuffered_out_pin_high = pull_high_ff;
    assign factory_test_bits       = test_ff;
endmodule : dac_mode_and_level_control

// ==== tb/dac_mode_and_level_control_properties.sv ====
// assertion checker for the converter control block
`timescale 1ns/100ps
module dac_mode_and_level_control_properties
#(
    parameter int LEVEL_W = 8
)
(
    input wire logic               hclk,
    input wire logic               hresetn,
    input wire logic               hsel,
    input wire logic [31:0]        haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic [2:0]         hsize,
    input wire logic [31:0]        hwdata,
    input wire logic               hready,
    input wire logic [31:0]        hrdata,
    input wire logic               hreadyout,
    input wire logic               hresp,
    input wire logic               cpu_stop,
    input wire logic               special_mode,
    input wire logic               wide_range_select,
    input wire logic               amp_high_drive,
    input wire logic [LEVEL_W-1:0] output_level_code,
    input wire logic               network_enable,
    input wire logic               amp_enable,
    input wire logic               feedback_switch,
    input wire logic               buffer_switch,
    input wire logic               direct_output_switch,
    input wire logic               unbuffered_out_pin_high,
    input wire logic [7:0]         factory_test_bits
);
    logic wr_taken_ff;
    logic nxt_wr_taken;

    // write address phase accepted on the bus
    always_comb nxt_wr_taken = hsel && hready && htrans[1] && hwrite;

    // remembers the accepted write address phase
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            wr_taken_ff <= 1'b0;
        else
            wr_taken_ff <= nxt_wr_taken;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_bus_okay_byte: assert property (
        hreadyout && !hresp && hrdata[31:8] == 24'h0)
        else $error("bus answer not okay or upper read bits set");
    a_test_top_zero: assert property (factory_test_bits[7] == 1'b0)
        else $error("test byte top bit set");
    a_stop_amp_off: assert property (
        $past(cpu_stop) |-> !amp_enable && !feedback_switch
        && !buffer_switch)
        else $error("amplifier path active in stop");
    a_buffer_route: assert property (
        buffer_switch |-> network_enable && amp_enable
        && !feedback_switch && !direct_output_switch)
        else $error("buffer switch with wrong routing");
    a_feedback_route: assert property (
        feedback_switch |-> amp_enable && !buffer_switch)
        else $error("feedback switch without amplifier");
    a_direct_route: assert property (
        direct_output_switch |-> network_enable && !buffer_switch)
        else $error("direct switch without network");
    a_config_hold: assert property (
        !$past(wr_taken_ff) |-> $stable(output_level_code)
        && $stable(wide_range_select) && $stable(amp_high_drive)
        && $stable(factory_test_bits))
        else $error("configuration changed without a write");
    a_pull_only_stop: assert property (
        unbuffered_out_pin_high |-> $past(cpu_stop))
        else $error("pull to high reference outside stop");
    a_pull_on_entry: assert property (
        $rose(cpu_stop) && direct_output_switch
        |-> ##1 unbuffered_out_pin_high)
        else $error("no pull to high reference on stop entry");
    a_pull_mode_only: assert property (
        $rose(unbuffered_out_pin_high) |-> $past(direct_output_switch))
        else $error("pull to high reference in a buffered mode");
endmodule : dac_mode_and_level_control_properties

bind dac_mode_and_level_control dac_mode_and_level_control_properties
    #(.LEVEL_W(LEVEL_W)) u_props
(
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cpu_stop(cpu_stop), .special_mode(special_mode),
    .wide_range_select(wide_range_select),
    .amp_high_drive(amp_high_drive),
    .output_level_code(output_level_code),
    .network_enable(network_enable), .amp_enable(amp_enable),
    .feedback_switch(feedback_switch), .buffer_switch(buffer_switch),
    .direct_output_switch(direct_output_switch),
    .unbuffered_out_pin_high(unbuffered_out_pin_high),
    .factory_test_bits(factory_test_bits)
);

// ==== tb/dac_mode_and_level_control_tb.sv ====
// self-checking bench for the converter control block
`timescale 1ns/100ps
module dac_mode_and_level_control_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        cpu_stop = 1'b0;
    logic        special_mode = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, wide_range_select, amp_high_drive;
    logic        network_enable, amp_enable, feedback_switch;
    logic        buffer_switch, direct_output_switch, pull_high;
    logic [7:0]  output_level_code, factory_test_bits, outs;
    int          failures = 0;
    int          compares = 0;
    // mode codes and expected {network, amp, feedback, buffer, direct}
    logic [2:0]  mode_tab [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h7};
    logic [4:0]  route_tab [6] = '{5'h00, 5'h0c, 5'h10, 5'h11, 5'h1d, 5'h1a};

    // packed view of the static outputs
    assign outs = {wide_range_select, amp_high_drive, pull_high,
                   network_enable, amp_enable, feedback_switch,
                   buffer_switch, direct_output_switch};

    always #25 hclk = ~hclk;

    dac_mode_and_level_control #(.LEVEL_W(8)) DUT
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .cpu_stop(cpu_stop), .special_mode(special_mode),
        .wide_range_select(wide_range_select),
        .amp_high_drive(amp_high_drive),
        .output_level_code(output_level_code),
        .network_enable(network_enable), .amp_enable(amp_enable),
        .feedback_switch(feedback_switch), .buffer_switch(buffer_switch),
        .direct_output_switch(direct_output_switch),
        .unbuffered_out_pin_high(pull_high),
        .factory_test_bits(factory_test_bits)
    );

    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // ends at the rising edge where hready is high; rd as sampled at the falling edge before it
    task automatic wait_ready(output logic [31:0] rd);
        logic rdy;
        for (int n = 0; n < 16; n++)
        begin
            @(negedge hclk);
            rd = hrdata;
            rdy = hreadyout;
            @(posedge hclk);
            if (rdy === 1'b1)
                return;
        end
        failures++;
        $display("unexpected hready wait expected 1 seen 0");
        summarize();
    endtask : wait_ready

    // one single transfer; called right after a rising edge
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= dac_ctrl_pkg::HTRANS_NONSEQ;
        wait_ready(rd);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready(rd);
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rd(input string name, input logic [31:0] a,
                      input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(name, exp, x);
    endtask : rd

    // lets n edges pass, then stops mid-cycle for checks
    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
    endtask : settle

    // main sequence
    initial
    begin
        logic [7:0] m;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        settle(0);
        chk("reset outputs", 32'h80, outs);
        @(posedge hclk);
        rd("reset control", 32'h00, 32'h80);
        rd("reset level", 32'h08, 32'h00);
        rd("reset test", 32'h1c, 32'h00);
        $display("test reset done");
        for (int i = 0; i < 6; i++)
        begin
            m = {5'h0f, mode_tab[i]};
            wr(32'h00, {24'hffffff, m});
            rd("control", 32'h00, {24'h0, m & 8'hc7});
            settle(0);
            chk("mode outputs", {24'h0, 3'h2, route_tab[i]},
                outs);
            @(posedge hclk);
            cpu_stop <= 1'b1;
            settle(2);
            chk("stop outputs", {24'h0, 2'h1, route_tab[i][0],
                route_tab[i] & 5'h11}, outs);
            @(posedge hclk);
            rd("stop control", 32'h00, {24'h0, m & 8'hc7});
            cpu_stop <= 1'b0;
            settle(2);
            chk("wake outputs", {24'h0, 3'h2, route_tab[i]}, outs);
            @(posedge hclk);
        end
        $display("test modes and stop done");
        for (int c = 3; c < 7; c += 3)
        begin
            wr(32'h00, 32'h80 | c);
            rd("reserved mode", 32'h00, 32'h87);
        end
        settle(0);
        chk("reserved outputs", 32'h9a, outs);
        @(posedge hclk);
        $display("test reserved modes done");
        for (int i = 0; i < 2; i++)
        begin
            m = (i == 0) ? 8'ha5 : 8'h5a;
            wr(32'h08, {24'hffffff, m});
            rd("level", 32'h08, {24'h0, m});
            chk("level out", {24'h0, m}, {24'h0, output_level_code});
        end
        $display("test level done");
        for (int i = 1; i < 9; i++)
            if (i != 2 && i != 7)
            begin
                wr(i * 4, 32'hffffffff);
                rd("spare", i * 4, 32'h0);
            end
        rd("level kept", 32'h08, 32'h5a);
        rd("control kept", 32'h00, 32'h87);
        $display("test spare offsets done");
        wr(32'h1c, 32'hff);
        rd("test locked", 32'h1c, 32'h0);
        special_mode <= 1'b1;
        wr(32'h1c, 32'hff);
        rd("test open", 32'h1c, 32'h7f);
        chk("test out", 32'h7f, {24'h0, factory_test_bits});
        special_mode <= 1'b0;
        $display("test factory byte done");
        hresetn <= 1'b0;
        settle(2);
        chk("rereset outputs", 32'h80, outs);
        chk("rereset bytes", 32'h0, {output_level_code,
            factory_test_bits});
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd("rereset control", 32'h00, 32'h80);
        $display("test second reset done");
        summarize();
    end
endmodule : dac_mode_and_level_control_tb
